// *** logic/diag_status_pkg.sv ***
// How it works
// (R01) Status word sent whenever its content changes
// (R02) Class 0 error sets status bit 7
// (R03) Class 1..4 error sets status bit 13
// (R04) Bits 0-6 show the operating state flags
// (R05) Bits 8-15 show halt, remote, motion flags
// (R06) Two latched error words readable over fieldbus
// (R07) Warning word: 32-bit record, 1 means activated
// (R08) Fault reset clears all warning bits; a bit whose source is active in the same cycle stays set
// (R09) Warning bits 10, 13 self-clear when cause gone
// (R10) Warning bits 0,2,4,5,6,8 mapped as listed
// (R11) Warning bits 10,13,16,17,18 mapped as listed
// (R12) Warning bits 20-23 flag option modules
// (R13) Warning bit 28 brake I2t, 31 motor I2t
// (R14) Signal word bit 30 start-up, 31 system error
// (R15) Reserved bits read zero, writes ignored
// (R16) Warning bit sets at once, holds until cleared
package diag_status_pkg;

    // Fieldbus register addresses
    localparam logic [15:0] ADDR_STATUS_WORD = 16'h1b04;
    localparam logic [15:0] ADDR_SIGNAL_WORD = 16'h1c10;
    localparam logic [15:0] ADDR_WARN_WORD   = 16'h1c18;

    // Status word field positions
    localparam int BIT_CLASS0_ERR  = 7;
    localparam int BIT_CLASS14_ERR = 13;

    // Warning word field positions and implemented-bit mask
    localparam int BIT_WARN_STO      = 10;
    localparam int BIT_WARN_LOW_VOLT = 13;
    localparam logic [31:0] WARN_VALID_MASK = 32'h90f7_2575;
    localparam logic [31:0] WARN_AUTO_CLEAR = 32'h0000_2400;

    // Signal word positions, mask and reset value
    localparam int BIT_SIG_STARTUP = 30;
    localparam int BIT_SIG_SYS_ERR = 31;
    localparam logic [31:0] SIG_VALID_MASK  = 32'hfcf7_ed7f;
    localparam logic [31:0] SIG_RESET_VALUE = 32'h4000_0000;

    // Operating state and motion flags from the drive core
    typedef struct packed {
        logic homing_valid;
        logic motion_ended;
        logic motion_error;
        logic mode_specific;
        logic internal_limit;
        logic target_reached;
        logic remote;
        logic halt_active;
        logic switch_on_disabled;
        logic quick_stop;
        logic voltage_enabled;
        logic fault;
        logic operation_enabled;
        logic switched_on;
        logic ready_to_switch_on;
    } drive_state_t;

    // Fieldbus read answer
    typedef struct packed {
        logic        valid;
        logic        err;
        logic [31:0] data;
    } rd_resp_t;

    typedef enum logic [1:0] {
        SEL_STATUS = 2'b00,
        SEL_SIGNAL = 2'b01,
        SEL_WARN   = 2'b10,
        SEL_NONE   = 2'b11
    } reg_sel_t;

endpackage

// *** logic/drive_diag_status_regs.sv ***
`timescale 1ns/1ps
module drive_diag_status_regs
    import diag_status_pkg::*;
(
    input  wire logic         i_mclk,
    input  wire logic         i_rst,
    input  wire logic         i_ce,
    input  wire drive_state_t i_state,
    input  wire logic [31:0]  i_warn_src,
    input  wire logic [31:0]  i_sig_src,
    input  wire logic         i_sys_error,
    input  wire logic         i_fault_reset,
    input  wire logic         i_rd_en,
    input  wire logic [15:0]  i_rd_addr,
    input  wire logic         i_wr_en,
    output rd_resp_t          o_rd_resp,
    output logic              o_wr_refused,
    output logic [15:0]       o_status_word,
    output logic              o_status_tx
);

    logic [31:0]  warn_q;
    logic [31:0]  warn_d;
    logic [31:0]  sig_q;
    logic [31:0]  sig_d;
    logic [15:0]  status_d;
    logic [15:0]  status_q;
    logic         tx_q;
    rd_resp_t     resp_q;
    logic         wr_ref_q;
    reg_sel_t     sel;

    // Address decode shared by read path
    function automatic reg_sel_t decode(input logic [15:0] addr);
        case (addr)
            ADDR_STATUS_WORD: decode = SEL_STATUS;
            ADDR_SIGNAL_WORD: decode = SEL_SIGNAL;
            ADDR_WARN_WORD:   decode = SEL_WARN;
            default:          decode = SEL_NONE;
        endcase
    endfunction

    // Warning latch: set beats fault reset so no event is lost
    always_comb begin
        warn_d = warn_q;
        if (i_fault_reset) begin
            warn_d = 32'h0000_0000; // R08
        end
        warn_d = (warn_d & ~WARN_AUTO_CLEAR) | (i_warn_src & WARN_VALID_MASK); // R07 R10 R12 R13 R16
        warn_d = warn_d | (i_warn_src & WARN_AUTO_CLEAR); // R09 R11
        warn_d = warn_d & WARN_VALID_MASK; // R15
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            warn_q <= 32'h0000_0000;
        end else if (i_ce) begin
            warn_q <= warn_d; // R06
        end
    end

    // Signal latch; start-up bit comes from the reset constant
    always_comb begin
        sig_d = i_fault_reset ? 32'h0000_0000 : sig_q;
        sig_d = sig_d | (i_sig_src & SIG_VALID_MASK);
        sig_d[BIT_SIG_SYS_ERR] = sig_d[BIT_SIG_SYS_ERR] | i_sys_error; // R14
        sig_d = sig_d & SIG_VALID_MASK; // R15
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            sig_q <= SIG_RESET_VALUE; // R14
        end else if (i_ce) begin
            sig_q <= sig_d; // R06
        end
    end

    // Status word assembly; bit 13 merges motion error and class 1..4
    always_comb begin
        status_d[0]  = i_state.ready_to_switch_on; // R04
        status_d[1]  = i_state.switched_on;
        status_d[2]  = i_state.operation_enabled;
        status_d[3]  = i_state.fault;
        status_d[4]  = i_state.voltage_enabled;
        status_d[5]  = i_state.quick_stop;
        status_d[6]  = i_state.switch_on_disabled;
        status_d[BIT_CLASS0_ERR] = |warn_q; // R02
        status_d[8]  = i_state.halt_active; // R05
        status_d[9]  = i_state.remote;
        status_d[10] = i_state.target_reached;
        status_d[11] = i_state.internal_limit;
        status_d[12] = i_state.mode_specific;
        status_d[BIT_CLASS14_ERR] = i_state.motion_error
            | (|(sig_q & ~SIG_RESET_VALUE)); // R03
        status_d[14] = i_state.motion_ended;
        status_d[15] = i_state.homing_valid;
    end

    // Event-driven send: one pulse per content change
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            status_q <= 16'h0000;
            tx_q     <= 1'b0;
        end else if (i_ce) begin
            status_q <= status_d;
            tx_q     <= (status_d != status_q); // R01
        end
    end

    assign sel = decode(i_rd_addr);

    // Read answer one cycle after the request; unmapped flags err
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            resp_q <= '0;
        end else if (i_ce) begin
            resp_q.valid <= i_rd_en;
            resp_q.err   <= i_rd_en && (sel == SEL_NONE);
            case (sel)
                SEL_STATUS: resp_q.data <= {16'h0000, status_q}; // R15
                SEL_SIGNAL: resp_q.data <= sig_q;
                SEL_WARN:   resp_q.data <= warn_q;
                default:    resp_q.data <= 32'h0000_0000;
            endcase
        end
    end

    // All words are read-only; a write only earns a refusal
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            wr_ref_q <= 1'b0;
        end else if (i_ce) begin
            wr_ref_q <= i_wr_en; // R15
        end
    end

    assign o_rd_resp     = resp_q;
    assign o_wr_refused  = wr_ref_q;
    assign o_status_word = status_q;
    assign o_status_tx   = tx_q;

    // Checks
    sequence s_fault_reset_quiet;
        i_ce && i_fault_reset && (i_warn_src == 32'h0000_0000);
    endsequence

    property p_warn_set;
        @(posedge i_mclk) disable iff (i_rst)
        (i_ce && |(i_warn_src & WARN_VALID_MASK))
            |=> ((warn_q & $past(i_warn_src & WARN_VALID_MASK))
                == $past(i_warn_src & WARN_VALID_MASK));
    endproperty
    a_warn_set: assert property (p_warn_set) else $error("warning source not latched"); // R16

    property p_warn_hold;
        @(posedge i_mclk) disable iff (i_rst)
        (i_ce && !i_fault_reset) |=> ((warn_q & ~WARN_AUTO_CLEAR & $past(warn_q))
            == ($past(warn_q) & ~WARN_AUTO_CLEAR));
    endproperty
    a_warn_hold: assert property (p_warn_hold) else $error("latched warning dropped"); // R16

    property p_fault_reset;
        @(posedge i_mclk) disable iff (i_rst)
        s_fault_reset_quiet |=> (warn_q == 32'h0000_0000);
    endproperty
    a_fault_reset: assert property (p_fault_reset) else $error("fault reset left bits"); // R08

    property p_auto_clear;
        @(posedge i_mclk) disable iff (i_rst)
        (i_ce && !i_warn_src[BIT_WARN_STO] && !i_warn_src[BIT_WARN_LOW_VOLT])
            |=> (!warn_q[BIT_WARN_STO] && !warn_q[BIT_WARN_LOW_VOLT]);
    endproperty
    a_auto_clear: assert property (p_auto_clear) else $error("bit 10 or 13 stuck"); // R09

    property p_reserved_zero;
        @(posedge i_mclk) disable iff (i_rst)
        ((warn_q & ~WARN_VALID_MASK) == 32'h0000_0000)
            && ((sig_q & ~SIG_VALID_MASK) == 32'h0000_0000);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set"); // R15

    property p_class0_bit;
        @(posedge i_mclk) disable iff (i_rst)
        (i_ce && |warn_q) |=> o_status_word[BIT_CLASS0_ERR];
    endproperty
    a_class0_bit: assert property (p_class0_bit) else $error("status bit 7 missing"); // R02

    property p_sys_err;
        @(posedge i_mclk) disable iff (i_rst)
        // Status follows only if the edge after the latch was enabled
        (i_ce && i_sys_error) |=> sig_q[BIT_SIG_SYS_ERR]
            ##1 (!$past(i_ce) || o_status_word[BIT_CLASS14_ERR]);
    endproperty
    a_sys_err: assert property (p_sys_err) else $error("system error not flagged"); // R14 R03

    property p_tx_on_change;
        @(posedge i_mclk) disable iff (i_rst)
        (i_ce && (status_d != status_q)) |=> o_status_tx;
    endproperty
    a_tx_on_change: assert property (p_tx_on_change) else $error("status change not sent"); // R01

    property p_no_tx_idle;
        @(posedge i_mclk) disable iff (i_rst)
        // A pulse held by a low enable is not a second send
        (o_status_tx && $past(i_ce)) |-> (o_status_word != $past(o_status_word, 1));
    endproperty
    a_no_tx_idle: assert property (p_no_tx_idle) else $error("send without change"); // R01

    property p_read_warn;
        @(posedge i_mclk) disable iff (i_rst)
        (i_ce && i_rd_en && (i_rd_addr == ADDR_WARN_WORD))
            |=> (o_rd_resp.valid && !o_rd_resp.err && (o_rd_resp.data == $past(warn_q)));
    endproperty
    a_read_warn: assert property (p_read_warn) else $error("warning read wrong"); // R06

    property p_read_status;
        @(posedge i_mclk) disable iff (i_rst)
        (i_ce && i_rd_en && (i_rd_addr == ADDR_STATUS_WORD))
            |=> (o_rd_resp.valid && (o_rd_resp.data == {16'h0000, $past(o_status_word)}));
    endproperty
    a_read_status: assert property (p_read_status) else $error("status read wrong"); // R15

    property p_read_unmapped;
        @(posedge i_mclk) disable iff (i_rst)
        (i_ce && i_rd_en && (sel == SEL_NONE))
            |=> (o_rd_resp.valid && o_rd_resp.err && (o_rd_resp.data == 32'h0000_0000));
    endproperty
    a_read_unmapped: assert property (p_read_unmapped) else $error("bad address not flagged"); // R15

    property p_wr_refused;
        @(posedge i_mclk) disable iff (i_rst)
        (i_ce && i_wr_en) |=> o_wr_refused;
    endproperty
    a_wr_refused: assert property (p_wr_refused) else $error("write not refused"); // R15

endmodule

// *** tb/fieldbus_master.sv ***
`timescale 1ns/1ps
// Fieldbus master: one-cycle read and write strobes
module fieldbus_master
    import diag_status_pkg::*;
(
    input  wire logic     i_mclk,
    input  wire rd_resp_t i_rd_resp,
    input  wire logic     i_wr_refused,
    output logic          o_rd_en,
    output logic [15:0]   o_rd_addr,
    output logic          o_wr_en
);
    // Idle bus at time zero
    initial begin
        o_rd_en = 1'b0;
        o_rd_addr = 16'h0000;
        o_wr_en = 1'b0;
    end

    // Strobe raised after one edge, answer registered at the next and read just after it
    task automatic read(input logic [15:0] a, output rd_resp_t r);
        @(posedge i_mclk);
        #1 o_rd_en = 1'b1;
        o_rd_addr = a;
        @(posedge i_mclk);
        #1 o_rd_en = 1'b0;
        o_rd_addr = ~a; // Released address never keeps the old value
        r = i_rd_resp;
    endtask

    // Writes are always refused, the pulse is the only answer
    task automatic write(output logic ref_seen);
        @(posedge i_mclk);
        #1 o_wr_en = 1'b1;
        @(posedge i_mclk);
        #1 o_wr_en = 1'b0;
        ref_seen = i_wr_refused;
    endtask
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
    import diag_status_pkg::*;
;
    logic         i_mclk;
    logic         rst;
    logic         ce;
    drive_state_t st;
    drive_state_t s;
    logic [31:0]  warn;
    logic [31:0]  sig;
    logic [31:0]  w;
    logic         sys_err;
    logic         frst;
    logic         rd_en;
    logic [15:0]  rd_addr;
    logic         wr_en;
    logic         refused;
    logic         ref_seen;
    logic [15:0]  sw;
    logic         tx;
    rd_resp_t     resp;
    rd_resp_t     r;
    int           errors;
    int           n_checks;
    int           cycles;

    drive_diag_status_regs uut (.i_mclk(i_mclk), .i_rst(rst), .i_ce(ce), .i_state(st),
        .i_warn_src(warn), .i_sig_src(sig), .i_sys_error(sys_err), .i_fault_reset(frst),
        .i_rd_en(rd_en), .i_rd_addr(rd_addr), .i_wr_en(wr_en), .o_rd_resp(resp),
        .o_wr_refused(refused), .o_status_word(sw), .o_status_tx(tx));

    fieldbus_master mst (.i_mclk(i_mclk), .i_rd_resp(resp), .i_wr_refused(refused),
        .o_rd_en(rd_en), .o_rd_addr(rd_addr), .o_wr_en(wr_en));

    // Clock, 4 ns period
    initial begin
        i_mclk = 1'b0;
        forever #2 i_mclk = ~i_mclk;
    end

    // Hang guard, far above the roughly 136 cycles needed
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            finish_test();
        end
    end

    function automatic logic [15:0] exp_status(drive_state_t x, logic c0, logic c1);
        return {x[14:13], x[12] | c1, x[11:7], c0, x[6:0]};
    endfunction

    // Bits 10 and 13 follow their source, so only the rest stay latched
    function automatic logic [31:0] exp_warn(logic [31:0] x);
        return x & WARN_VALID_MASK & ~WARN_AUTO_CLEAR;
    endfunction

    task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        mst.read(a, r);
        chk("rd_resp", {2'b10, e}, r);
    endtask

    task automatic pulse_reset();
        @(posedge i_mclk);
        #1 frst = 1'b1;
        @(posedge i_mclk);
        #1 frst = 1'b0;
    endtask

    task automatic finish_test();
        if (errors == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        void'($urandom(32'hb5ee));
        {rst, ce, st, warn, sig, sys_err, frst} = {2'b11, 15'h0000, 64'h0, 2'b00};
        repeat (2) @(posedge i_mclk);
        #1 rst = 1'b0;
        rd(ADDR_SIGNAL_WORD, SIG_RESET_VALUE);
        rd(ADDR_WARN_WORD, 32'h0);
        rd(ADDR_STATUS_WORD, 32'h0);
        for (int k = 0; k < 8; k++) begin
            w = (k == 0) ? 32'hffff_ffff : $urandom();
            s = drive_state_t'(15'($urandom()));
            s.motion_error = 1'b0;
            @(posedge i_mclk);
            #1 warn = w;
            st = s;
            @(posedge i_mclk);
            #1 warn = 32'h0; // One-cycle source must still latch
            repeat (3) @(posedge i_mclk);
            #1 chk("status_word", exp_status(s, |exp_warn(w), 1'b0), sw);
            rd(ADDR_STATUS_WORD, exp_status(s, |exp_warn(w), 1'b0));
            rd(ADDR_WARN_WORD, exp_warn(w));
            pulse_reset();
            rd(ADDR_WARN_WORD, 32'h0);
        end
        warn = WARN_AUTO_CLEAR;
        rd(ADDR_WARN_WORD, WARN_AUTO_CLEAR);
        warn = 32'h0;
        rd(ADDR_WARN_WORD, 32'h0);
        sig = 32'h1;
        rd(ADDR_SIGNAL_WORD, 32'h1);
        sig = 32'h0;
        sys_err = 1'b1;
        rd(ADDR_SIGNAL_WORD, 32'h8000_0001);
        sys_err = 1'b0;
        chk("status_word", exp_status(st, 1'b0, 1'b1), sw);
        pulse_reset();
        mst.read(16'h1c14, r);
        chk("rd_unmapped", 34'h3_0000_0000, r);
        mst.write(ref_seen);
        chk("wr_refused", 34'h1, ref_seen);
        @(posedge i_mclk);
        #1 ce = 1'b0; // Frozen: no send while disabled
        st.remote = ~st.remote;
        repeat (2) @(posedge i_mclk);
        #1 chk("status_tx", 34'h0, tx);
        ce = 1'b1;
        @(posedge i_mclk);
        #1 chk("status_tx", 34'h1, tx);
        chk("status_word", exp_status(st, 1'b0, 1'b0), sw);
        @(posedge i_mclk);
        #1 chk("status_tx", 34'h0, tx);
        rst = 1'b1; // Mid-run reset brings the start-up bit back
        @(posedge i_mclk);
        #1 chk("status_word", 34'h0, sw);
        chk("status_tx", 34'h0, tx);
        rst = 1'b0;
        rd(ADDR_SIGNAL_WORD, SIG_RESET_VALUE);
        rd(ADDR_WARN_WORD, 32'h0);
        chk("status_word", exp_status(st, 1'b0, 1'b0), sw);
        finish_test();
    end
endmodule
